//--- verilog/dmr_pkg.sv
// Purpose: Shared constants and types for the repeat/normal/block DMA channel
// Assumes: Word-indexed register port, 16-bit data path on the system bus
// Notes: Register offsets are word indices on the plain register port
package dmr_pkg;
	// Register offsets
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_STAT = 5'h01;
	localparam logic [4:0] OFF_MEM = 5'h02;
	localparam logic [4:0] OFF_PERIPH = 5'h03;
	localparam logic [4:0] OFF_RPT_RUN = 5'h04;
	localparam logic [4:0] OFF_RPT_INIT = 5'h05;
	localparam logic [4:0] OFF_SRC = 5'h06;
	localparam logic [4:0] OFF_DST = 5'h07;
	localparam logic [4:0] OFF_PAIR_CNT = 5'h08;
	localparam logic [4:0] OFF_BSZ_RUN = 5'h09;
	localparam logic [4:0] OFF_BSZ_INIT = 5'h0a;
	localparam logic [4:0] OFF_BLK_CNT = 5'h0b;
	// Control register field positions
	localparam int C_EN = 0;
	localparam int C_IE = 1;
	localparam int C_SZ = 2;
	localparam int C_DIR = 3;
	localparam int C_MODE = 4;
	localparam int C_SRC = 6;
	localparam int C_DST = 8;
	localparam int C_BURST = 10;
	localparam int C_AREA = 11;
	localparam int C_LEVEL = 12;
	localparam int C_TRIG = 13;
	localparam int CTRL_W = 16;
	// Status register field positions
	localparam int S_BUSY = 0;
	localparam int S_DONE = 1;
	localparam int S_PEND = 2;
	localparam int S_DIR = 3;
	// Trigger select codes; codes below TRG_EXT index i_trig directly
	localparam int NTRIG = 6;
	localparam logic [2:0] TRG_TMR2 = 3'h2;
	localparam logic [2:0] TRG_TX = 3'h3;
	localparam logic [2:0] TRG_RX = 3'h4;
	localparam logic [2:0] TRG_ADC = 3'h5;
	localparam logic [2:0] TRG_EXT = 3'h6;
	localparam logic [2:0] TRG_AUTO = 3'h7;
	// Address and reset constants
	localparam logic [15:0] PERIPH_HI = 16'hffff;
	localparam logic [23:0] PTR_RST = 24'h0000;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [23:0] STEP_BYTE = 24'h0001;
	localparam logic [23:0] STEP_WORD = 24'h0002;
	localparam logic [7:0] CNT8_ONE = 8'h01;
	localparam logic [15:0] CNT16_ONE = 16'h0001;
	typedef enum logic [1:0] {MODE_REPEAT, MODE_NORMAL, MODE_BLOCK, MODE_RSVD} dmr_mode_t;
	typedef enum logic [1:0] {STEP_HOLD, STEP_INC, STEP_DEC, STEP_RSVD} dmr_step_t;
endpackage

//--- verilog/dmr_req_if.sv
// Purpose: Carries request state between the front end and the engine
// Assumes: Both ends on i_clk
// Notes: take is a one-cycle pulse from the engine
`timescale 1ns/1ps
interface dmr_req_if;
	logic en;
	logic [1:0] mode;
	logic [2:0] sel;
	logic level;
	logic take;
	logic pending;
	logic from_rx;
	modport front(input en, input mode, input sel, input level, input take, output pending, output from_rx);
	modport engine(output en, output mode, output sel, output level, output take, input pending, input from_rx);
endinterface

//--- verilog/dmr_req_front.sv
// Purpose: Selects, qualifies and holds activation requests
// Assumes: i_trig pulses come from on-chip logic on i_clk
// Notes: The external request pin is synchronised before any use
`timescale 1ns/1ps
module dmr_req_front
	import dmr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [dmr_pkg::NTRIG-1:0] i_trig,
	input wire logic i_ext_req_n,
	dmr_req_if.front rq
);
	logic ext_s1, ext_s2, ext_prev, held;
	logic fall, int_hit, int_ok, lvl_ok, hit;
	dmr_mode_t mode;

	// Two-stage synchroniser plus edge history on the second stage only
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ext_s1 <= 1'b1;
			ext_s2 <= 1'b1;
			ext_prev <= 1'b1;
		end else begin
			ext_s1 <= i_ext_req_n;
			ext_s2 <= ext_s1;
			ext_prev <= ext_s2;
		end
	end

	// Repeat mode takes all six internal sources
	// Block mode refuses the serial pair
	always_comb begin
		mode = dmr_mode_t'(rq.mode);
		fall = ext_prev & ~ext_s2;
		int_hit = (rq.sel < TRG_EXT) && i_trig[rq.sel];
		int_ok = (mode == MODE_REPEAT) || ((mode == MODE_BLOCK) && (rq.sel <= TRG_TMR2 || rq.sel == TRG_ADC));
		lvl_ok = rq.level && (mode != MODE_BLOCK);
		hit = rq.en && ((int_hit && int_ok) || ((rq.sel == TRG_EXT) && fall && !lvl_ok && mode != MODE_RSVD));
	end

	// Edge-type requests are held until taken; a new hit beats the take
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			held <= 1'b0;
		end else if (hit) begin
			held <= 1'b1;
		end else if (rq.take) begin
			held <= 1'b0;
		end
	end

	// Auto-request is a standing request in normal mode
	assign rq.pending = rq.en && (held || ((rq.sel == TRG_EXT) && lvl_ok && !ext_s2)
		|| ((rq.sel == TRG_AUTO) && mode == MODE_NORMAL));
	// Receive-full and converter-done move data into memory
	assign rq.from_rx = (rq.sel == TRG_RX) || (rq.sel == TRG_ADC);

	// a_serial_block_refused
	a_serial_block_refused: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(mode == MODE_BLOCK && (rq.sel == TRG_TX || rq.sel == TRG_RX) && !held) |=> !held)
		else $error("serial trigger accepted in block mode");
endmodule

//--- verilog/dmr_channel.sv
// Purpose: One DMA channel engine with repeat, normal and block transfer modes
// Assumes: System bus grants with i_bus_grant and ends each access with i_bus_ack
// Notes: Each transfer is one read then one write; the bus request drops to release
// Functional notes
// - Repeat: per-request unit, restore and continue
// - Repeat pointer steps, then returns
// - Repeat direction follows trigger source
// - Running count decrements, reloads from initial
// - Restore pointer by signed size-scaled count
// - Repeat count eight bits, max 255
// - Repeat runs until disabled, no interrupt
// - Peripheral address upper sixteen bits ones
// - Repeat triggers: timers, serial, converter, external
// - Normal: 24-bit source, destination independently stepped
// - Normal count zero ends, optional interrupt
// - Normal: external or auto request
// - Cycle-steal releases; burst holds unless preempted
// - Block: size count reloads, pointer restored
// - Area select zero restores destination
// - Block count zero ends, optional interrupt
// - Block triggers exclude serial requests
// - Block external requests are edge only
// - Transfer end low on block's last write
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module dmr_channel
	import dmr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [4:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic [dmr_pkg::NTRIG-1:0] i_trig,
	input wire logic i_ext_req_n,
	output logic o_bus_req,
	input wire logic i_bus_grant,
	input wire logic i_bus_preempt,
	output logic [23:0] o_bus_addr,
	output logic o_bus_rd,
	output logic o_bus_wr,
	output logic o_bus_word,
	output logic [15:0] o_bus_wdata,
	input wire logic [15:0] i_bus_rdata,
	input wire logic i_bus_ack,
	output logic o_transfer_end_n,
	output logic o_completion_irq
);
	typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_READ, ST_WRITE, ST_REL} dmr_state_t;
	dmr_state_t state;
	logic [CTRL_W-1:0] ctrl;
	logic [23:0] mem_ptr, src_ptr, dst_ptr, blk_base;
	logic [7:0] periph_lo, rpt_run, rpt_init, bsz_run, bsz_init;
	logic [15:0] pcnt, blk_cnt;
	logic done, dir_rx;
	logic en, sz, fin, last, stop, more, wr_any, take;
	logic [23:0] rpt_src, rpt_dst, next_mem, rpt_ofs;
	dmr_mode_t mode;
	dmr_step_t src_mode, dst_mode;
	dmr_req_if rq ();

	// Pointer step by mode and unit size
	function automatic logic [23:0] step_ptr(input logic [23:0] p, input dmr_step_t m, input logic w);
		logic [23:0] d;
		d = w ? STEP_WORD : STEP_BYTE;
		unique case (m)
			STEP_INC: step_ptr = p + d;
			STEP_DEC: step_ptr = p - d;
			default: step_ptr = p;
		endcase
	endfunction

	// Software write hit for one offset
	function automatic logic wr_hit(input logic [4:0] off);
		wr_hit = i_wr && (i_addr == off);
	endfunction

	dmr_req_front u_front (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_trig(i_trig),
		.i_ext_req_n(i_ext_req_n),
		.rq(rq)
	);

	// Control field decode
	always_comb begin
		en = ctrl[C_EN];
		sz = ctrl[C_SZ];
		mode = dmr_mode_t'(ctrl[C_MODE+:2]);
		src_mode = dmr_step_t'(ctrl[C_SRC+:2]);
		dst_mode = dmr_step_t'(ctrl[C_DST+:2]);
		wr_any = i_wr;
	end

	assign rq.en = en;
	assign rq.mode = ctrl[C_MODE+:2];
	assign rq.sel = ctrl[C_TRIG+:3];
	assign rq.level = ctrl[C_LEVEL];
	// Only an enabled channel leaves idle
	assign take = (state == ST_IDLE) && en && rq.pending;
	assign rq.take = take;

	// Repeat addressing and restore arithmetic
	always_comb begin
		rpt_src = dir_rx ? {PERIPH_HI, periph_lo} : mem_ptr;
		rpt_dst = dir_rx ? mem_ptr : {PERIPH_HI, periph_lo};
		rpt_ofs = sz ? {15'h0000, rpt_init, 1'b0} : {16'h0000, rpt_init};
		next_mem = step_ptr(mem_ptr, ctrl[C_DIR] ? STEP_DEC : STEP_INC, sz);
		// Restore subtracts when stepping up, adds when stepping down
		if (rpt_run == CNT8_ONE) begin
			next_mem = ctrl[C_DIR] ? next_mem + rpt_ofs : next_mem - rpt_ofs;
		end
	end

	// Completion of the write access and end-of-activation decisions
	always_comb begin
		fin = (state == ST_WRITE) && i_bus_ack;
		unique case (mode)
			MODE_NORMAL: last = (pcnt == CNT16_ONE);
			MODE_BLOCK: last = (bsz_run == CNT8_ONE);
			default: last = 1'b0;
		endcase
		more = en && !last && ((mode == MODE_BLOCK)
			|| (mode == MODE_NORMAL && ctrl[C_BURST] && rq.sel == TRG_AUTO));
		// A block run ends only with its last block, not with each block
		stop = last && ((mode == MODE_NORMAL) || (blk_cnt == CNT16_ONE));
	end

	// Transfer sequencer
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: if (take) state <= ST_ARB;
				ST_ARB: if (i_bus_grant) state <= ST_READ;
				ST_READ: if (i_bus_ack) state <= ST_WRITE;
				ST_WRITE: begin
					// Preemption releases after the current unit
					if (i_bus_ack) state <= !more ? ST_IDLE : (i_bus_preempt ? ST_REL : ST_ARB);
				end
				ST_REL: state <= ST_ARB;
			endcase
		end
	end

	// Bus address and write data; loaded at each access start
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_bus_addr <= PTR_RST;
			o_bus_wdata <= CNT_RST;
		end else if (state == ST_ARB && i_bus_grant) begin
			// Paired modes read from the source pointer
			o_bus_addr <= (mode == MODE_REPEAT) ? rpt_src : src_ptr;
		end else if (state == ST_READ && i_bus_ack) begin
			o_bus_addr <= (mode == MODE_REPEAT) ? rpt_dst : dst_ptr;
			o_bus_wdata <= i_bus_rdata;
		end
	end

	// Direction latched per activation so a mid-transfer select change is harmless
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dir_rx <= 1'b0;
		end else if (take) begin
			dir_rx <= rq.from_rx;
		end
	end

	// Bus handshake strobes follow the state directly
	assign o_bus_req = (state == ST_ARB) || (state == ST_READ) || (state == ST_WRITE);
	assign o_bus_rd = (state == ST_READ);
	assign o_bus_wr = (state == ST_WRITE);
	assign o_bus_word = sz;
	// Low during the final write of a block or of a normal run
	assign o_transfer_end_n = !((state == ST_WRITE) && last);

	// Control register; software write overrides the hardware end-clear
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl <= CNT_RST;
		end else begin
			if (fin && stop) ctrl[C_EN] <= 1'b0;
			if (wr_hit(OFF_CTRL)) ctrl <= i_wdata[CTRL_W-1:0];
		end
	end

	// Done flag and completion interrupt; the set beats the software clear
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			done <= 1'b0;
			o_completion_irq <= 1'b0;
		end else begin
			// Repeat mode never reaches here with stop set
			o_completion_irq <= fin && stop && ctrl[C_IE];
			if (fin && stop) begin
				done <= 1'b1;
			end else if (wr_hit(OFF_STAT)) begin
				done <= 1'b0;
			end
		end
	end

	// Repeat registers
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mem_ptr <= PTR_RST;
			periph_lo <= BYTE_RST;
			rpt_run <= BYTE_RST;
			rpt_init <= BYTE_RST;
		end else begin
			if (fin && mode == MODE_REPEAT) begin
				mem_ptr <= next_mem;
				// Eight-bit count reloads from initial in place of stepping from one to zero
				rpt_run <= (rpt_run == CNT8_ONE) ? rpt_init : rpt_run - CNT8_ONE;
			end
			if (wr_hit(OFF_MEM)) mem_ptr <= i_wdata[23:0];
			if (wr_hit(OFF_PERIPH)) periph_lo <= i_wdata[7:0];
			if (wr_hit(OFF_RPT_RUN)) rpt_run <= i_wdata[7:0];
			if (wr_hit(OFF_RPT_INIT)) rpt_init <= i_wdata[7:0];
		end
	end

	// Paired pointers and counters
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			src_ptr <= PTR_RST;
			dst_ptr <= PTR_RST;
			pcnt <= CNT_RST;
			bsz_run <= BYTE_RST;
			bsz_init <= BYTE_RST;
			blk_cnt <= CNT_RST;
		end else begin
			if (fin && mode != MODE_REPEAT) begin
				src_ptr <= step_ptr(src_ptr, src_mode, sz);
				dst_ptr <= step_ptr(dst_ptr, dst_mode, sz);
			end
			// Zero loaded gives the full 16-bit run
			if (fin && mode == MODE_NORMAL) pcnt <= pcnt - CNT16_ONE;
			// Block size counts down per transfer
			if (fin && mode == MODE_BLOCK) begin
				bsz_run <= bsz_run - CNT8_ONE;
				if (bsz_run == CNT8_ONE) begin
					bsz_run <= bsz_init;
					blk_cnt <= blk_cnt - CNT16_ONE;
					// Area select zero restores the destination
					if (ctrl[C_AREA]) src_ptr <= blk_base;
					else dst_ptr <= blk_base;
				end
			end
			if (wr_hit(OFF_SRC)) src_ptr <= i_wdata[23:0];
			if (wr_hit(OFF_DST)) dst_ptr <= i_wdata[23:0];
			if (wr_hit(OFF_PAIR_CNT)) pcnt <= i_wdata[15:0];
			if (wr_hit(OFF_BSZ_RUN)) bsz_run <= i_wdata[7:0];
			if (wr_hit(OFF_BSZ_INIT)) bsz_init <= i_wdata[7:0];
			if (wr_hit(OFF_BLK_CNT)) blk_cnt <= i_wdata[15:0];
		end
	end

	// Block-area start captured when a fresh block begins
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			blk_base <= PTR_RST;
		end else if (take && mode == MODE_BLOCK && bsz_run == bsz_init) begin
			blk_base <= ctrl[C_AREA] ? src_ptr : dst_ptr;
		end
	end

	// Read data, valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= 32'h0000_0000;
		end else if (i_rd) begin
			o_rdata <= 32'h0000_0000;
			unique case (i_addr)
				OFF_CTRL: o_rdata[CTRL_W-1:0] <= ctrl;
				OFF_STAT: o_rdata[S_DIR:S_BUSY] <= {dir_rx, rq.pending, done, state != ST_IDLE};
				OFF_MEM: o_rdata[23:0] <= mem_ptr;
				OFF_PERIPH: o_rdata[7:0] <= periph_lo;
				OFF_RPT_RUN: o_rdata[7:0] <= rpt_run;
				OFF_RPT_INIT: o_rdata[7:0] <= rpt_init;
				OFF_SRC: o_rdata[23:0] <= src_ptr;
				OFF_DST: o_rdata[23:0] <= dst_ptr;
				OFF_PAIR_CNT: o_rdata[15:0] <= pcnt;
				OFF_BSZ_RUN: o_rdata[7:0] <= bsz_run;
				OFF_BSZ_INIT: o_rdata[7:0] <= bsz_init;
				OFF_BLK_CNT: o_rdata[15:0] <= blk_cnt;
				default: o_rdata <= 32'h0000_0000;
			endcase
		end
	end

	// Checks on the engine's own behaviour
	a_repeat_reload: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(fin && mode == MODE_REPEAT && rpt_run == CNT8_ONE && !wr_any) |=> rpt_run == $past(rpt_init))
		else $error("repeat count not reloaded");
	a_repeat_restore: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(fin && mode == MODE_REPEAT && rpt_run == CNT8_ONE && !ctrl[C_DIR] && sz && !wr_any)
		|=> mem_ptr == 24'($past(mem_ptr) + STEP_WORD - {15'h0000, $past(rpt_init), 1'b0}))
		else $error("repeat pointer restore wrong");
	a_repeat_keeps_on: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(fin && mode == MODE_REPEAT && en && !wr_any) |=> en ##1 !o_completion_irq)
		else $error("repeat mode stopped or interrupted");
	a_periph_upper: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == ST_WRITE && mode == MODE_REPEAT && !dir_rx) |-> o_bus_addr[23:8] == PERIPH_HI)
		else $error("peripheral address upper bits not ones");
	a_rx_reads_periph: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == ST_READ && mode == MODE_REPEAT && dir_rx) |-> o_bus_addr[23:8] == PERIPH_HI)
		else $error("receive transfer not from peripheral");
	a_normal_end: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(fin && mode == MODE_NORMAL && last && !wr_any) |=> !en && o_completion_irq == $past(ctrl[C_IE]))
		else $error("normal run did not end cleanly");
	a_steal_release: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(fin && mode == MODE_NORMAL && !ctrl[C_BURST]) |=> !o_bus_req)
		else $error("cycle-steal kept the bus");
	a_block_restore: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(fin && mode == MODE_BLOCK && last && !ctrl[C_AREA] && !wr_any) |=> dst_ptr == $past(blk_base))
		else $error("block area not restored");
	a_block_end_pin: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == ST_WRITE && mode == MODE_BLOCK && bsz_run == CNT8_ONE) |-> !o_transfer_end_n)
		else $error("transfer end not low on last write");
	a_off_stays_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == ST_IDLE && !en) |=> state == ST_IDLE)
		else $error("disabled channel started");
	a_auto_starts: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state == ST_IDLE && en && mode == MODE_NORMAL && rq.sel == TRG_AUTO) |=> state == ST_ARB ##[1:20] o_bus_rd)
		else $error("auto-request did not start");
	a_burst_holds_bus: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(fin && more && !i_bus_preempt) |=> o_bus_req)
		else $error("burst dropped the bus");
	a_preempt_release: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(fin && more && i_bus_preempt) |=> !o_bus_req ##1 o_bus_req)
		else $error("preempted burst did not release and resume");
	a_block_keeps_on: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(fin && mode == MODE_BLOCK && last && blk_cnt != CNT16_ONE && !wr_any) |=> en && !o_completion_irq)
		else $error("block run ended early");
endmodule

//--- tb/dmr_bus_model.sv
// Purpose: System bus stand-in that grants the channel and answers its accesses
// Assumes: One access at a time; grant follows the request one cycle late
// Notes: Read data are a pattern of the address; outside an ack they are inverted
`timescale 1ns/1ps
module dmr_bus_model (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_req,
	input wire logic [23:0] i_addr,
	input wire logic i_rd,
	input wire logic i_wr,
	input wire logic [1:0] i_delay,
	output logic o_grant,
	output logic o_ack,
	output logic [15:0] o_rdata
);
	logic [1:0] wait_cnt;
	// Grant trails the request, so a release is seen before the next grant
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_grant <= 1'b0;
		end else begin
			o_grant <= i_req;
		end
	end
	// One-cycle ack after a chosen wait, to mimic slow memory as well
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wait_cnt <= 2'h0;
			o_ack <= 1'b0;
		end else if (o_ack) begin
			wait_cnt <= 2'h0;
			o_ack <= 1'b0;
		end else if (i_rd || i_wr) begin
			o_ack <= (wait_cnt == i_delay);
			wait_cnt <= wait_cnt + 2'h1;
		end
	end
	// Stale data never match, since the simulator would otherwise settle them kindly
	assign o_rdata = (o_ack && i_rd) ? (i_addr[15:0] ^ 16'ha5c3) : ~(i_addr[15:0] ^ 16'ha5c3);
endmodule

//--- tb/dmr_channel_tb_top.sv
// Purpose: Register-driven tests of repeat, normal and block transfers
// Assumes: Bus model answers every access; preemption is held high for one burst run
// Notes: Every bus write is logged with its address, data and end flag
`timescale 1ns/1ps
module dmr_channel_tb_top;
	import dmr_pkg::*;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [4:0] i_addr = 5'h00;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [5:0] i_trig = 6'h00;
	logic i_ext_req_n = 1'b1;
	logic i_bus_preempt = 1'b0;
	logic [1:0] delay = 2'h0;
	logic [15:0] dmask = 16'hffff;
	logic [31:0] o_rdata;
	logic o_bus_req, i_bus_grant, o_bus_rd, o_bus_wr, o_bus_word, i_bus_ack, o_transfer_end_n, o_completion_irq;
	logic [23:0] o_bus_addr;
	logic [15:0] o_bus_wdata, i_bus_rdata;
	logic [23:0] w_addr[$];
	logic [23:0] r_addr[$];
	logic [15:0] w_data[$];
	logic w_end[$], w_word[$];
	int failures = 0;
	int n_compared = 0;
	int n_irq = 0;
	localparam logic [23:0] PA = {PERIPH_HI, 8'h40};
	dmr_channel dmr_channel_inst (.i_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_trig,
		.i_ext_req_n, .o_bus_req, .i_bus_grant, .i_bus_preempt, .o_bus_addr, .o_bus_rd, .o_bus_wr, .o_bus_word,
		.o_bus_wdata, .i_bus_rdata, .i_bus_ack, .o_transfer_end_n, .o_completion_irq);
	dmr_bus_model dmr_bus_model_inst (.i_clk, .i_reset_n, .i_req(o_bus_req), .i_addr(o_bus_addr), .i_rd(o_bus_rd),
		.i_wr(o_bus_wr), .i_delay(delay), .o_grant(i_bus_grant), .o_ack(i_bus_ack), .o_rdata(i_bus_rdata));
	// Clock, 5 ns period
	always #2.5 i_clk = ~i_clk;
	// Log completed accesses; values are those before this edge's updates
	always @(posedge i_clk) begin
		if (i_bus_ack && o_bus_wr) begin
			w_addr.push_back(o_bus_addr);
			w_data.push_back(o_bus_wdata);
			w_end.push_back(o_transfer_end_n);
			w_word.push_back(o_bus_word);
		end
		if (i_bus_ack && o_bus_rd) r_addr.push_back(o_bus_addr);
		if (o_completion_irq) n_irq++;
	end
	task automatic test_done;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// Strobe held for one cycle, then one idle cycle so calls never collide
	task automatic reg_wr(input logic [4:0] a, input logic [31:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic reg_chk(input string what, input logic [4:0] a, input logic [31:0] exp);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk(what, exp, o_rdata);
		@(posedge i_clk);
	endtask
	task automatic pulse(input int k);
		i_trig <= 6'h01 << k;
		@(posedge i_clk);
		i_trig <= 6'h00;
		@(posedge i_clk);
	endtask
	task automatic wait_wr(input int n);
		for (int i = 0; i < 400 && w_addr.size() < n; i++) @(posedge i_clk);
		if (w_addr.size() < n) chk("write count", n, w_addr.size());
		repeat (6) @(posedge i_clk);
	endtask
	task automatic chk_wr(input int i, input logic [23:0] wa, input logic [23:0] ra, input logic e);
		chk("read address", ra, r_addr[i]);
		chk("write address", wa, w_addr[i]);
		chk("write data", (ra[15:0] ^ 16'ha5c3) & dmask, w_data[i] & dmask);
		chk("transfer end", e, w_end[i]);
	endtask
	function automatic logic [31:0] ctl(input logic en, ie, sz, dir, input logic [1:0] md, ss, ds, input logic [2:0] tg);
		return {16'h0000, tg, 3'h0, ds, ss, md, dir, sz, ie, en};
	endfunction
	// Hang guard of 20000 cycles, far beyond the few hundred cycles the tests need
	initial begin
		#100000;
		failures++;
		test_done;
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge i_clk);
		i_reset_n <= 1'b1;
		repeat (4) @(posedge i_clk);
		reg_chk("control reset", OFF_CTRL, 32'h0000_0000);
		reg_chk("block count reset", OFF_BLK_CNT, 32'h0000_0000);
		reg_wr(5'h1f, 32'h0000_1234);
		reg_chk("unmapped", 5'h1f, 32'h0000_0000);
		reg_wr(OFF_MEM, 32'h0000_1000);
		reg_wr(OFF_PERIPH, 32'h0000_0040);
		reg_wr(OFF_RPT_RUN, 32'h0000_0002);
		reg_wr(OFF_RPT_INIT, 32'h0000_0002);
		reg_wr(OFF_CTRL, ctl(1, 0, 1, 0, MODE_REPEAT, STEP_HOLD, STEP_HOLD, 3'h0));
		pulse(0);
		wait_wr(1);
		pulse(0);
		wait_wr(2);
		chk_wr(0, PA, 24'h00_1000, 1'b1);
		chk_wr(1, PA, 24'h00_1002, 1'b1);
		chk("word access", 1, w_word[0]);
		reg_chk("pointer restored", OFF_MEM, 32'h0000_1000);
		reg_chk("running reloaded", OFF_RPT_RUN, 32'h0000_0002);
		reg_chk("initial kept", OFF_RPT_INIT, 32'h0000_0002);
		reg_wr(OFF_CTRL, ctl(0, 0, 1, 0, MODE_REPEAT, STEP_HOLD, STEP_HOLD, 3'h0));
		pulse(0);
		repeat (30) @(posedge i_clk);
		chk("writes while off", 2, w_addr.size());
		reg_wr(OFF_CTRL, ctl(1, 0, 1, 0, MODE_REPEAT, STEP_HOLD, STEP_HOLD, 3'h0));
		pulse(0);
		wait_wr(3);
		chk_wr(2, PA, 24'h00_1000, 1'b1);
		reg_chk("pointer resumed", OFF_MEM, 32'h0000_1002);
		chk("repeat interrupts", 0, n_irq);
		reg_wr(OFF_CTRL, 32'h0000_0000);
		reg_wr(OFF_MEM, 32'h0000_2000);
		reg_wr(OFF_RPT_RUN, 32'h0000_0003);
		reg_wr(OFF_RPT_INIT, 32'h0000_0003);
		reg_wr(OFF_CTRL, ctl(1, 0, 0, 1, MODE_REPEAT, STEP_HOLD, STEP_HOLD, TRG_RX));
		dmask = 16'h00ff;
		pulse(4);
		wait_wr(4);
		chk_wr(3, 24'h00_2000, PA, 1'b1);
		reg_chk("byte step down", OFF_MEM, 32'h0000_1fff);
		reg_wr(OFF_CTRL, 32'h0000_0000);
		reg_wr(OFF_MEM, 32'h0000_7000);
		reg_wr(OFF_RPT_RUN, 32'h0000_00ff);
		reg_wr(OFF_RPT_INIT, 32'h0000_00ff);
		reg_wr(OFF_CTRL, ctl(1, 0, 1, 0, MODE_REPEAT, STEP_HOLD, STEP_HOLD, TRG_EXT));
		dmask = 16'hffff;
		i_ext_req_n <= 1'b0;
		repeat (8) @(posedge i_clk);
		i_ext_req_n <= 1'b1;
		wait_wr(5);
		chk_wr(4, PA, 24'h00_7000, 1'b1);
		reg_chk("full count step", OFF_RPT_RUN, 32'h0000_00fe);
		reg_wr(OFF_CTRL, 32'h0000_0000);
		reg_wr(OFF_SRC, 32'h0000_3000);
		reg_wr(OFF_DST, 32'h0000_4000);
		reg_wr(OFF_PAIR_CNT, 32'h0000_0003);
		reg_wr(OFF_CTRL, ctl(1, 1, 1, 0, MODE_NORMAL, STEP_INC, STEP_INC, TRG_AUTO));
		wait_wr(8);
		chk_wr(5, 24'h00_4000, 24'h00_3000, 1'b1);
		chk_wr(6, 24'h00_4002, 24'h00_3002, 1'b1);
		chk_wr(7, 24'h00_4004, 24'h00_3004, 1'b0);
		chk("normal interrupt", 1, n_irq);
		reg_chk("normal ends", OFF_CTRL, ctl(0, 1, 1, 0, MODE_NORMAL, STEP_INC, STEP_INC, TRG_AUTO));
		reg_chk("source end", OFF_SRC, 32'h0000_3006);
		reg_wr(OFF_CTRL, 32'h0000_0000);
		reg_wr(OFF_SRC, 32'h0000_5000);
		reg_wr(OFF_DST, 32'h0000_6000);
		reg_wr(OFF_BSZ_RUN, 32'h0000_0002);
		reg_wr(OFF_BSZ_INIT, 32'h0000_0002);
		reg_wr(OFF_BLK_CNT, 32'h0000_0002);
		delay <= 2'h2;
		reg_wr(OFF_CTRL, ctl(1, 1, 1, 0, MODE_BLOCK, STEP_INC, STEP_INC, TRG_TX));
		pulse(3);
		repeat (40) @(posedge i_clk);
		chk("serial in block", 8, w_addr.size());
		reg_wr(OFF_CTRL, 32'h0000_0000);
		reg_wr(OFF_CTRL, ctl(1, 1, 1, 0, MODE_BLOCK, STEP_INC, STEP_INC, TRG_ADC));
		pulse(5);
		wait_wr(10);
		chk_wr(8, 24'h00_6000, 24'h00_5000, 1'b1);
		chk_wr(9, 24'h00_6002, 24'h00_5002, 1'b0);
		reg_chk("area restored", OFF_DST, 32'h0000_6000);
		reg_chk("blocks left", OFF_BLK_CNT, 32'h0000_0001);
		reg_chk("size reloaded", OFF_BSZ_RUN, 32'h0000_0002);
		pulse(5);
		wait_wr(12);
		chk_wr(10, 24'h00_6000, 24'h00_5004, 1'b1);
		chk_wr(11, 24'h00_6002, 24'h00_5006, 1'b0);
		chk("block interrupt", 2, n_irq);
		reg_chk("block ends", OFF_CTRL, ctl(0, 1, 1, 0, MODE_BLOCK, STEP_INC, STEP_INC, TRG_ADC));
		reg_chk("done set", OFF_STAT, 32'h0000_000a);
		reg_wr(OFF_STAT, 32'h0000_0000);
		reg_chk("done cleared", OFF_STAT, 32'h0000_0008);
		reg_wr(OFF_CTRL, 32'h0000_0000);
		reg_wr(OFF_SRC, 32'h0000_3100);
		reg_wr(OFF_DST, 32'h0000_4100);
		reg_wr(OFF_PAIR_CNT, 32'h0000_0002);
		dmask = 16'h00ff;
		i_bus_preempt <= 1'b1;
		reg_wr(OFF_CTRL, ctl(1, 0, 0, 0, MODE_NORMAL, STEP_DEC, STEP_HOLD, TRG_AUTO) | 32'h0000_0400);
		wait_wr(14);
		chk_wr(12, 24'h00_4100, 24'h00_3100, 1'b1);
		chk_wr(13, 24'h00_4100, 24'h00_30ff, 1'b0);
		chk("byte access", 0, w_word[13]);
		reg_chk("burst count out", OFF_PAIR_CNT, 32'h0000_0000);
		test_done;
	end
endmodule
